//--- verilog/rhs_pkg.sv
// constants and types for the root hub global status block
package rhs_pkg;
  localparam int unsigned RHS_ADR_W = 8;
  localparam int unsigned RHS_DAT_W = 32;
  localparam int unsigned RHS_MAX_PORTS = 15;
  localparam logic [7:0] RHS_OFF_STATUS = 8'h00;
  localparam logic [7:0] RHS_OFF_CONFIG = 8'h04;
  localparam logic [7:0] RHS_OFF_PWR_MASK = 8'h08;
  localparam logic [7:0] RHS_OFF_PWR_STATE = 8'h0C;
  localparam logic [7:0] RHS_OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] RHS_OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] RHS_OFF_CONTROL = 8'h18;
  localparam int unsigned RHS_BIT_CLR_WAKE = 31;
  localparam int unsigned RHS_BIT_OC_CHANGE = 17;
  localparam int unsigned RHS_BIT_PWR_ON = 16;
  localparam int unsigned RHS_BIT_LP_CHANGE = 16;
  localparam int unsigned RHS_BIT_WAKE = 15;
  localparam int unsigned RHS_BIT_OC = 1;
  localparam int unsigned RHS_BIT_PWR_OFF = 0;
  localparam int unsigned RHS_BIT_LP_STATE = 0;
  localparam int unsigned RHS_CFG_SCHEME = 0;
  localparam int unsigned RHS_CFG_PERPORT_OC = 1;
  localparam int unsigned RHS_CFG_W = 2;
  localparam int unsigned RHS_IRQ_RESUME = 0;
  localparam int unsigned RHS_IRQ_OC = 1;
  localparam int unsigned RHS_IRQ_W = 2;
  localparam int unsigned RHS_CTL_SUSPEND = 0;
  localparam int unsigned RHS_CTL_RESUMED = 1;
  localparam logic RHS_RST_WAKE = 1'h0;
  localparam logic [1:0] RHS_RST_CONFIG = 2'h0;
  localparam logic [1:0] RHS_RST_IRQ_MASK = 2'h0;
  localparam logic [1:0] RHS_CODE_RUN = 2'h0;
  localparam logic [1:0] RHS_CODE_SUSPENDED = 2'h1;
  localparam logic [1:0] RHS_CODE_RESUMING = 2'h2;
  typedef enum logic [1:0] {
    RHS_RUN,
    RHS_SUSPENDED,
    RHS_RESUMING
  } rhs_ctl_state_type;
endpackage

//--- verilog/rhs_change_flag.sv
// level tracker with a sticky change flag, cleared by a strobe
`timescale 1ns/1ps
module rhs_change_flag (
  input wire logic clock,
  input wire logic rst,
  input wire logic level,
  input wire logic clear,
  output logic level_q,
  output logic change_event,
  output logic change_flag
);
  assign change_event = level != level_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      level_q <= 1'h0;
    end else begin
      level_q <= level;
    end
  end

  // a change in the clearing cycle still lands: set beats clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      change_flag <= 1'h0;
    end else begin
      change_flag <= (change_flag & ~clear) | change_event;
    end
  end
endmodule

//--- verilog/rhs_port_power.sv
// per-port power state switched by the global on and off commands
`timescale 1ns/1ps
module rhs_port_power #(
  parameter int unsigned NUM_PORTS = 2
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic power_on,
  input wire logic power_off,
  input wire logic per_port_scheme,
  input wire logic [NUM_PORTS-1:0] port_power_mask,
  output logic [NUM_PORTS-1:0] port_power_state
);
  genvar i;
  generate
    for (i = 0; i < NUM_PORTS; i++) begin : g_port
      logic affected;
      // masked ports are owned by per-port control in per-port scheme
      assign affected = ~per_port_scheme | ~port_power_mask[i]; // see RULE5 RULE6 RULE7 RULE8
      // off wins over on when both are written at once, the safer side
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          port_power_state[i] <= 1'h0;
        end else if (affected && power_off) begin
          port_power_state[i] <= 1'h0;
        end else if (affected && power_on) begin
          port_power_state[i] <= 1'h1;
        end
      end
    end
  endgenerate
endmodule

//--- verilog/rhs_top.sv
// root hub global status register bank with wishbone slave
//
// Contract
// RULE1 - bit 31 write one clears wake enable
// RULE2 - overcurrent indicator change sets bit 17
// RULE3 - bit 17 cleared by one, zero ignored
// RULE4 - bits 16 and 0 always read zero
// RULE5 - global scheme: bit 16 powers all ports
// RULE6 - per-port scheme: bit 16 powers unmasked ports
// RULE7 - global scheme: bit 0 unpowers all ports
// RULE8 - per-port scheme: bit 0 unpowers unmasked ports
// RULE9 - wake enabled connect change resumes, raises interrupt
// RULE10 - bit 15 write one sets wake enable
// RULE11 - bit 1 shows global overcurrent condition
// RULE12 - per-port overcurrent mode: bit 1 reads zero
// RULE13 - reserved bits read zero, writes ignored
//
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
module rhs_top #(
  parameter int unsigned NUM_PORTS = 2
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [rhs_pkg::RHS_ADR_W-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [rhs_pkg::RHS_DAT_W-1:0] wb_dat_w,
  output logic [rhs_pkg::RHS_DAT_W-1:0] wb_dat_r,
  output logic wb_ack,
  input wire logic overcurrent,
  input wire logic [NUM_PORTS-1:0] connect_change,
  output logic [NUM_PORTS-1:0] port_power_state,
  output logic irq
);
  generate
    if (NUM_PORTS < 1 || NUM_PORTS > rhs_pkg::RHS_MAX_PORTS) begin : g_bad
      $error("rhs_top: NUM_PORTS must be 1 to 15");
    end
  endgenerate

  function automatic logic hit(input logic [rhs_pkg::RHS_ADR_W-1:0] adr,
                               input logic [7:0] off);
    hit = adr[rhs_pkg::RHS_ADR_W-1:2] == off[7:2];
  endfunction

  function automatic logic [31:0] lanes(input logic [3:0] sel);
    lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  logic req;
  logic wr_fire;
  logic [31:0] wd;
  logic [31:0] rd;
  logic cmd_status;
  logic cmd_config;
  logic cmd_mask;
  logic cmd_irq_status;
  logic cmd_irq_mask;
  logic cmd_control;
  logic wake_set;
  logic wake_clr;
  logic oc_chg_clr;
  logic pwr_on;
  logic pwr_off;
  logic remote_wake_enable;
  logic [rhs_pkg::RHS_CFG_W-1:0] config_bits;
  logic per_port_scheme;
  logic per_port_oc;
  logic [NUM_PORTS-1:0] port_power_mask;
  logic [rhs_pkg::RHS_IRQ_W-1:0] irq_status;
  logic [rhs_pkg::RHS_IRQ_W-1:0] irq_mask;
  logic [rhs_pkg::RHS_IRQ_W-1:0] irq_set;
  logic oc_level;
  logic global_overcurrent_flag;
  logic global_overcurrent_change;
  logic oc_event;
  logic resume_event;
  logic [1:0] state_code;
  rhs_pkg::rhs_ctl_state_type state;

  assign req = wb_cyc & wb_stb;
  // writes land on the edge where ack is seen high, as the master expects
  assign wr_fire = req & wb_we & wb_ack;
  assign wd = wb_dat_w & lanes(wb_sel);
  assign cmd_status = wr_fire & hit(wb_adr, rhs_pkg::RHS_OFF_STATUS);
  assign cmd_config = wr_fire & hit(wb_adr, rhs_pkg::RHS_OFF_CONFIG);
  assign cmd_mask = wr_fire & hit(wb_adr, rhs_pkg::RHS_OFF_PWR_MASK);
  assign cmd_irq_status = wr_fire & hit(wb_adr, rhs_pkg::RHS_OFF_IRQ_STATUS);
  assign cmd_irq_mask = wr_fire & hit(wb_adr, rhs_pkg::RHS_OFF_IRQ_MASK);
  assign cmd_control = wr_fire & hit(wb_adr, rhs_pkg::RHS_OFF_CONTROL);

  // reserved write bits simply have no decode
  assign wake_set = cmd_status & wd[rhs_pkg::RHS_BIT_WAKE]; // see RULE10 RULE13
  assign wake_clr = cmd_status & wd[rhs_pkg::RHS_BIT_CLR_WAKE]; // see RULE1
  assign oc_chg_clr = cmd_status & wd[rhs_pkg::RHS_BIT_OC_CHANGE]; // see RULE3
  assign pwr_on = cmd_status & wd[rhs_pkg::RHS_BIT_PWR_ON];
  assign pwr_off = cmd_status & wd[rhs_pkg::RHS_BIT_PWR_OFF];

  assign per_port_scheme = config_bits[rhs_pkg::RHS_CFG_SCHEME];
  assign per_port_oc = config_bits[rhs_pkg::RHS_CFG_PERPORT_OC];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wb_ack <= 1'h0;
    end else begin
      wb_ack <= req & ~wb_ack;
    end
  end

  // read data is captured with ack so it is stable while ack is high
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wb_dat_r <= 32'h00000000;
    end else if (req && !wb_ack) begin
      wb_dat_r <= rd;
    end
  end

  always_comb begin
    rd = 32'h00000000;
    if (hit(wb_adr, rhs_pkg::RHS_OFF_STATUS)) begin
      // local power bits and reserved ranges stay at zero
      rd[rhs_pkg::RHS_BIT_OC_CHANGE] = global_overcurrent_change; // see RULE4 RULE13
      rd[rhs_pkg::RHS_BIT_WAKE] = remote_wake_enable;
      rd[rhs_pkg::RHS_BIT_OC] = global_overcurrent_flag; // see RULE11
    end else if (hit(wb_adr, rhs_pkg::RHS_OFF_CONFIG)) begin
      rd = 32'(config_bits);
    end else if (hit(wb_adr, rhs_pkg::RHS_OFF_PWR_MASK)) begin
      rd = 32'(port_power_mask);
    end else if (hit(wb_adr, rhs_pkg::RHS_OFF_PWR_STATE)) begin
      rd = 32'(port_power_state);
    end else if (hit(wb_adr, rhs_pkg::RHS_OFF_IRQ_STATUS)) begin
      rd = 32'(irq_status);
    end else if (hit(wb_adr, rhs_pkg::RHS_OFF_IRQ_MASK)) begin
      rd = 32'(irq_mask);
    end else if (hit(wb_adr, rhs_pkg::RHS_OFF_CONTROL)) begin
      rd = 32'(state_code);
    end
  end

  // clear wins when both command bits are written together
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      remote_wake_enable <= rhs_pkg::RHS_RST_WAKE;
    end else if (wake_clr) begin
      remote_wake_enable <= 1'h0; // see RULE1
    end else if (wake_set) begin
      remote_wake_enable <= 1'h1; // see RULE10
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      config_bits <= rhs_pkg::RHS_RST_CONFIG;
    end else if (cmd_config) begin
      config_bits <= wd[rhs_pkg::RHS_CFG_W-1:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      port_power_mask <= '0;
    end else if (cmd_mask) begin
      port_power_mask <= wd[NUM_PORTS-1:0];
    end
  end

  // per-port protection hides the global indicator entirely
  assign oc_level = per_port_oc ? 1'h0 : overcurrent; // see RULE12

  rhs_change_flag u_oc_flag (
    .clock(clock),
    .rst(rst),
    .level(oc_level),
    .clear(oc_chg_clr), // see RULE3
    .level_q(global_overcurrent_flag), // see RULE11
    .change_event(oc_event), // see RULE2
    .change_flag(global_overcurrent_change)
  );

  rhs_port_power #(
    .NUM_PORTS(NUM_PORTS)
  ) u_power (
    .clock(clock),
    .rst(rst),
    .power_on(pwr_on), // see RULE5 RULE6
    .power_off(pwr_off), // see RULE7 RULE8
    .per_port_scheme(per_port_scheme),
    .port_power_mask(port_power_mask),
    .port_power_state(port_power_state)
  );

  // wake only counts while suspended and enabled
  assign resume_event = (state == rhs_pkg::RHS_SUSPENDED) && remote_wake_enable
                        && |connect_change; // see RULE9

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= rhs_pkg::RHS_RUN;
    end else begin
      case (state)
        rhs_pkg::RHS_RUN: begin
          if (cmd_control && wd[rhs_pkg::RHS_CTL_SUSPEND]) begin
            state <= rhs_pkg::RHS_SUSPENDED;
          end
        end
        rhs_pkg::RHS_SUSPENDED: begin
          if (resume_event) begin
            state <= rhs_pkg::RHS_RESUMING; // see RULE9
          end
        end
        rhs_pkg::RHS_RESUMING: begin
          if (cmd_control && wd[rhs_pkg::RHS_CTL_RESUMED]) begin
            state <= rhs_pkg::RHS_RUN;
          end
        end
        default: begin
          state <= rhs_pkg::RHS_RUN;
        end
      endcase
    end
  end

  always_comb begin
    case (state)
      rhs_pkg::RHS_SUSPENDED: state_code = rhs_pkg::RHS_CODE_SUSPENDED;
      rhs_pkg::RHS_RESUMING: state_code = rhs_pkg::RHS_CODE_RESUMING;
      default: state_code = rhs_pkg::RHS_CODE_RUN;
    endcase
  end

  always_comb begin
    irq_set = '0;
    irq_set[rhs_pkg::RHS_IRQ_RESUME] = resume_event; // see RULE9
    irq_set[rhs_pkg::RHS_IRQ_OC] = oc_event;
  end

  // set beats the write-one clear so no event is lost
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_status <= '0;
    end else if (cmd_irq_status) begin
      irq_status <= (irq_status & ~wd[rhs_pkg::RHS_IRQ_W-1:0]) | irq_set;
    end else begin
      irq_status <= irq_status | irq_set;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_mask <= rhs_pkg::RHS_RST_IRQ_MASK;
    end else if (cmd_irq_mask) begin
      irq_mask <= wd[rhs_pkg::RHS_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq <= 1'h0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  logic status_read;
  assign status_read = wb_ack && !wb_we && hit(wb_adr, rhs_pkg::RHS_OFF_STATUS);

  property p_wake_clear;
    wake_clr |=> !remote_wake_enable;
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("wake enable not cleared"); // see RULE1

  property p_oc_change_set;
    oc_event |=> global_overcurrent_change && irq_status[rhs_pkg::RHS_IRQ_OC];
  endproperty
  a_oc_change_set: assert property (p_oc_change_set) else $error("overcurrent change lost"); // see RULE2

  property p_oc_zero_ignored;
    cmd_status && !wd[rhs_pkg::RHS_BIT_OC_CHANGE] && global_overcurrent_change
      |=> global_overcurrent_change;
  endproperty
  a_oc_zero_ignored: assert property (p_oc_zero_ignored) else $error("zero write cleared flag"); // see RULE3

  property p_local_power_zero;
    status_read |-> !wb_dat_r[rhs_pkg::RHS_BIT_LP_CHANGE] && !wb_dat_r[rhs_pkg::RHS_BIT_LP_STATE];
  endproperty
  a_local_power_zero: assert property (p_local_power_zero) else $error("local power bit set"); // see RULE4

  property p_power_on_global;
    pwr_on && !pwr_off && !per_port_scheme |=> &port_power_state;
  endproperty
  a_power_on_global: assert property (p_power_on_global) else $error("not all ports on"); // see RULE5

  property p_power_on_port;
    pwr_on && !pwr_off && per_port_scheme
      |=> ((port_power_state | $past(port_power_mask)) == '1)
      && ((port_power_state & $past(port_power_mask))
      == ($past(port_power_state) & $past(port_power_mask)));
  endproperty
  a_power_on_port: assert property (p_power_on_port) else $error("per-port on wrong"); // see RULE6

  property p_power_off_global;
    pwr_off && !per_port_scheme |=> port_power_state == '0;
  endproperty
  a_power_off_global: assert property (p_power_off_global) else $error("ports still on"); // see RULE7

  property p_power_off_port;
    pwr_off && per_port_scheme
      |=> ((port_power_state & ~$past(port_power_mask)) == '0)
      && ((port_power_state & $past(port_power_mask))
      == ($past(port_power_state) & $past(port_power_mask)));
  endproperty
  a_power_off_port: assert property (p_power_off_port) else $error("per-port off wrong"); // see RULE8

  property p_resume;
    resume_event |=> state == rhs_pkg::RHS_RESUMING && irq_status[rhs_pkg::RHS_IRQ_RESUME]
      ##1 (irq || !$past(irq_mask[rhs_pkg::RHS_IRQ_RESUME]));
  endproperty
  a_resume: assert property (p_resume) else $error("resume not taken"); // see RULE9

  property p_wake_set;
    wake_set && !wake_clr |=> remote_wake_enable;
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake enable not set"); // see RULE10

  property p_oci_read;
    status_read |-> wb_dat_r[rhs_pkg::RHS_BIT_OC] == $past(global_overcurrent_flag);
  endproperty
  a_oci_read: assert property (p_oci_read) else $error("indicator read mismatch"); // see RULE11

  property p_oci_perport;
    per_port_oc ##1 per_port_oc |-> !global_overcurrent_flag;
  endproperty
  a_oci_perport: assert property (p_oci_perport) else $error("indicator set in per-port mode"); // see RULE12

  property p_reserved_zero;
    status_read |-> wb_dat_r[30:18] == '0 && wb_dat_r[14:2] == '0 && !wb_dat_r[31];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // see RULE13

  property p_ack_one_cycle;
    req && !wb_ack |=> wb_ack ##1 !wb_ack;
  endproperty
  a_ack_one_cycle: assert property (p_ack_one_cycle) else $error("ack timing wrong");

  c_resume: cover property (resume_event ##[1:4] irq);
  c_oc_toggle: cover property (oc_event ##[1:20] oc_chg_clr);
  c_per_port_on: cover property (pwr_on && per_port_scheme && |port_power_mask);
  c_set_during_clear: cover property (oc_event && oc_chg_clr);
endmodule

//--- bench/rhs_port_model.sv
// downstream port side: overcurrent level and connect change pulses
`timescale 1ns/1ps
module rhs_port_model #(
  parameter int unsigned NUM_PORTS = 2
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic oc_req,
  input wire logic [NUM_PORTS-1:0] conn_req,
  output logic overcurrent,
  output logic [NUM_PORTS-1:0] connect_change
);
  // registered so the level reaches the block one edge after the request
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      overcurrent <= 1'b0;
      connect_change <= '0;
    end else begin
      overcurrent <= oc_req;
      connect_change <= conn_req;
    end
  end
endmodule

//--- bench/rhs_top_tb.sv
// self-checking bench for the root hub global status block
`timescale 1ns/1ps
module rhs_top_tb;
  localparam int unsigned NP = 3;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h00000000;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  logic overcurrent;
  logic [NP-1:0] connect_change;
  logic [NP-1:0] port_power_state;
  logic irq;
  logic oc_req = 1'b0;
  logic [NP-1:0] conn_req = '0;
  int error_cnt = 0;
  int compares = 0;

  always #2.5 clock = ~clock;

  rhs_top #(.NUM_PORTS(NP)) dut_u (.clock(clock), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .overcurrent(overcurrent), .connect_change(connect_change),
    .port_power_state(port_power_state), .irq(irq));

  rhs_port_model #(.NUM_PORTS(NP)) port_u (.clock(clock), .rst(rst), .oc_req(oc_req),
    .conn_req(conn_req), .overcurrent(overcurrent), .connect_change(connect_change));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // one classic cycle; no fixed latency assumed, only the watchdog bounds the wait
  task automatic wb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= 4'hF;
    wb_dat_w <= d;
    do begin
      @(posedge clock);
    end while (wb_ack !== 1'b1);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(a, 1'b1, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] q;
    wb_xfer(a, 1'b0, 32'h00000000, q);
    chk(q, exp, msg);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic t_reset_and_reserved();
    chk({29'h0, port_power_state}, 32'h0, "power after reset");
    chk({31'h0, irq}, 32'h0, "irq after reset");
    rd_chk(8'h00, 32'h00000000, "status after reset");
    wr(8'h00, 32'h7FFC7FFC);
    rd_chk(8'h00, 32'h00000000, "reserved bits");
    wr(8'h40, 32'hFFFFFFFF);
    rd_chk(8'h40, 32'h00000000, "unmapped read");
  endtask

  task automatic t_wake_enable();
    wr(8'h00, 32'h00008000);
    rd_chk(8'h00, 32'h00008000, "wake set");
    wr(8'h00, 32'h00000000);
    rd_chk(8'h00, 32'h00008000, "wake held on zero");
    wr(8'h00, 32'h80000000);
    rd_chk(8'h00, 32'h00000000, "wake cleared");
  endtask

  task automatic t_power();
    wr(8'h00, 32'h00010000);
    settle(2);
    chk({29'h0, port_power_state}, 32'h7, "global power on");
    rd_chk(8'h00, 32'h00000000, "bits 16 and 0 read zero");
    wr(8'h00, 32'h00000000);
    settle(2);
    chk({29'h0, port_power_state}, 32'h7, "zero write keeps power");
    wr(8'h00, 32'h00000001);
    settle(2);
    chk({29'h0, port_power_state}, 32'h0, "global power off");
    wr(8'h04, 32'h00000001);
    wr(8'h08, 32'h00000005);
    wr(8'h00, 32'h00010000);
    settle(2);
    chk({29'h0, port_power_state}, 32'h2, "per-port on");
    wr(8'h04, 32'h00000000);
    wr(8'h00, 32'h00010000);
    wr(8'h04, 32'h00000001);
    wr(8'h00, 32'h00000001);
    settle(2);
    chk({29'h0, port_power_state}, 32'h5, "per-port off");
    rd_chk(8'h0C, 32'h00000005, "power state readback");
    wr(8'h04, 32'h00000000);
  endtask

  task automatic t_overcurrent();
    wr(8'h14, 32'h00000002);
    @(posedge clock);
    oc_req <= 1'b1;
    settle(6);
    chk({31'h0, irq}, 32'h1, "irq on change");
    rd_chk(8'h00, 32'h00020002, "oc flag and change");
    wr(8'h00, 32'h00000000);
    rd_chk(8'h00, 32'h00020002, "zero keeps change");
    wr(8'h00, 32'h00020000);
    rd_chk(8'h00, 32'h00000002, "change cleared");
    wr(8'h10, 32'h00000002);
    settle(3);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    @(posedge clock);
    oc_req <= 1'b0;
    settle(6);
    rd_chk(8'h00, 32'h00020000, "normal power, change");
    chk({31'h0, irq}, 32'h1, "irq on fall");
    wr(8'h14, 32'h00000000);
    settle(3);
    chk({31'h0, irq}, 32'h0, "irq masked");
    rd_chk(8'h10, 32'h00000002, "status kept while masked");
    wr(8'h10, 32'h00000003);
    wr(8'h00, 32'h00020000);
    wr(8'h04, 32'h00000002);
    @(posedge clock);
    oc_req <= 1'b1;
    settle(6);
    rd_chk(8'h00, 32'h00000000, "per-port oc reads zero");
    @(posedge clock);
    oc_req <= 1'b0;
    settle(4);
    wr(8'h04, 32'h00000000);
  endtask

  task automatic t_resume();
    wr(8'h14, 32'h00000001);
    wr(8'h00, 32'h00008000);
    wr(8'h18, 32'h00000001);
    rd_chk(8'h18, 32'h00000001, "suspended");
    @(posedge clock);
    conn_req <= 3'h2;
    @(posedge clock);
    conn_req <= 3'h0;
    settle(5);
    rd_chk(8'h18, 32'h00000002, "resuming on connect change");
    rd_chk(8'h10, 32'h00000001, "resume seen");
    chk({31'h0, irq}, 32'h1, "resume irq");
    wr(8'h18, 32'h00000002);
    wr(8'h10, 32'h00000001);
    wr(8'h00, 32'h80000000);
    wr(8'h18, 32'h00000001);
    @(posedge clock);
    conn_req <= 3'h1;
    @(posedge clock);
    conn_req <= 3'h0;
    settle(5);
    rd_chk(8'h18, 32'h00000001, "no wake when disabled");
    chk({31'h0, irq}, 32'h0, "no resume irq");
  endtask

  // whole sequence is a few hundred cycles; limit is far beyond it
  initial begin
    #100000;
    error_cnt++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    settle(1);
    t_reset_and_reserved();
    t_wake_enable();
    t_power();
    t_overcurrent();
    t_resume();
    tally_and_finish();
  end
endmodule
